// ==== logic/slalu_top.sv ====
// Subtract and logic ALU slice with flag update and register write-back
// Contract
// [RQ1] Subtract register or immediate; ZCNVH; one cycle
// [RQ2] Subtract register and carry; ZCNVH; one cycle
// [RQ3] Subtract immediate and carry; ZCNVH; one cycle
// [RQ4] Word subtract immediate on pair; ZCNVS; two cycles
// [RQ5] AND register or immediate; ZNV; one cycle
// [RQ6] OR register or immediate; ZNV; one cycle
// [RQ7] XOR registers; ZNV updated
// [RQ8] One's and two's complement of destination
// [RQ9] Unnamed flags and other registers untouched
`include "slalu_map.svh"
module slalu_top (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Request from decoder, operands read from register file
	input wire slalu_pkg::slalu_req_t req_i,
	input wire logic use_imm_i,
	// Write-back to register file, busy and status flags
	output slalu_pkg::slalu_wb_t wb_o,
	output logic busy_o,
	output logic [7:0] flags_o
);
	typedef struct packed {
		slalu_pkg::slalu_state_t st;
		slalu_pkg::slalu_wb_t wb;
		logic [7:0] hi;
		logic [4:0] hi_addr;
		logic [7:0] fval;
		logic [7:0] fupd;
	} slalu_st_t;

	slalu_st_t s_q, s_d;
	logic [7:0] flags;

	slalu_flag_reg #(.WIDTH(8)) u_flags (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.upd_i(s_q.fupd),
		.val_i(s_q.fval),
		.flags_o(flags)
	);

	logic [7:0] opnd;
	logic cin;
	logic c_now;
	logic z_now;
	logic [8:0] diff;
	logic [4:0] hdiff;
	logic [15:0] wres;
	logic [7:0] lres;
	always_comb begin
		// Forward flags still in flight so back-to-back borrow ops chain
		c_now = s_q.fupd[`SLALU_FLAG_C] ? s_q.fval[`SLALU_FLAG_C] : flags[`SLALU_FLAG_C];
		z_now = s_q.fupd[`SLALU_FLAG_Z] ? s_q.fval[`SLALU_FLAG_Z] : flags[`SLALU_FLAG_Z];
		opnd = use_imm_i ? req_i.imm : req_i.src_reg;
		cin = 1'b0;
		if (req_i.op == `SLALU_OP_SUBB_REG || req_i.op == `SLALU_OP_SUBB_IMM) begin
			cin = c_now; // RQ2
		end
		diff = {1'b0, req_i.rd} - {1'b0, opnd} - {8'h00, cin}; // RQ1
		hdiff = {1'b0, req_i.rd[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
		wres = {req_i.rdh, req_i.rd} - {10'h000, req_i.imm[5:0]}; // RQ4
		case (req_i.op)
			`SLALU_OP_AND: lres = req_i.rd & opnd; // RQ5
			`SLALU_OP_OR: lres = req_i.rd | opnd; // RQ6
			`SLALU_OP_XOR: lres = req_i.rd ^ req_i.src_reg; // RQ7
			`SLALU_OP_INV: lres = ~req_i.rd; // RQ8
			default: lres = 8'h00 - req_i.rd; // RQ8
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.wb.we = 1'b0;
		s_d.fupd = 8'h00; // RQ9
		case (s_q.st)
			slalu_pkg::SLALU_IDLE: begin
				if (req_i.valid) begin
					s_d.wb.addr = req_i.dst;
					s_d.wb.we = 1'b1;
					case (req_i.op)
						`SLALU_OP_SUB_REG, `SLALU_OP_SUB_IMM,
						`SLALU_OP_SUBB_REG, `SLALU_OP_SUBB_IMM: begin
							s_d.wb.data = diff[7:0];
							s_d.fupd = 8'h2F;
							s_d.fval[`SLALU_FLAG_C] = diff[8];
							s_d.fval[`SLALU_FLAG_N] = diff[7];
							s_d.fval[`SLALU_FLAG_V] = (req_i.rd[7] ^ opnd[7]) & (req_i.rd[7] ^ diff[7]);
							s_d.fval[`SLALU_FLAG_H] = hdiff[4];
							// Borrow forms set Z only on a zero result with Z already set
							if (req_i.op == `SLALU_OP_SUBB_REG || req_i.op == `SLALU_OP_SUBB_IMM) begin
								s_d.fval[`SLALU_FLAG_Z] = (diff[7:0] == 8'h00) & z_now; // RQ3
							end else begin
								s_d.fval[`SLALU_FLAG_Z] = (diff[7:0] == 8'h00); // RQ1
							end
						end
						`SLALU_OP_WSUB_IMM: begin
							s_d.wb.data = wres[7:0]; // RQ4
							s_d.hi = wres[15:8];
							s_d.hi_addr = 5'(req_i.dst + 5'h01);
							s_d.st = slalu_pkg::SLALU_WORD_HI;
							s_d.fupd = 8'h1F;
							s_d.fval[`SLALU_FLAG_C] = wres[15] & ~req_i.rdh[7];
							s_d.fval[`SLALU_FLAG_Z] = (wres == 16'h0000);
							s_d.fval[`SLALU_FLAG_N] = wres[15];
							s_d.fval[`SLALU_FLAG_V] = req_i.rdh[7] & ~wres[15];
							s_d.fval[`SLALU_FLAG_S] = wres[15] ^ (req_i.rdh[7] & ~wres[15]);
						end
						`SLALU_OP_AND, `SLALU_OP_OR, `SLALU_OP_XOR: begin
							s_d.wb.data = lres;
							s_d.fupd = 8'h0E; // RQ9
							s_d.fval[`SLALU_FLAG_Z] = (lres == 8'h00);
							s_d.fval[`SLALU_FLAG_N] = lres[7];
							s_d.fval[`SLALU_FLAG_V] = 1'b0;
						end
						`SLALU_OP_INV, `SLALU_OP_TWOS: begin
							// Flags for complements are left to the core
							s_d.wb.data = lres; // RQ8
						end
						default: begin
							s_d.wb.we = 1'b0;
						end
					endcase
				end
			end
			slalu_pkg::SLALU_WORD_HI: begin
				s_d.wb.we = 1'b1; // RQ4
				s_d.wb.addr = s_q.hi_addr;
				s_d.wb.data = s_q.hi;
				s_d.st = slalu_pkg::SLALU_IDLE;
			end
			default: s_d.st = slalu_pkg::SLALU_IDLE;
		endcase
		s_d.fval[7:6] = 2'b00;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	logic busy_q;
	logic [7:0] flags_q;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wb_o <= '0;
			busy_q <= 1'b0;
			flags_q <= `SLALU_FLAGS_RST;
		end else begin
			wb_o <= s_q.wb;
			busy_q <= (s_d.st == slalu_pkg::SLALU_WORD_HI);
			flags_q <= flags;
		end
	end
	assign busy_o = busy_q;
	assign flags_o = flags_q;

	sequence s_word_req;
		req_i.valid && req_i.op == `SLALU_OP_WSUB_IMM && s_q.st == slalu_pkg::SLALU_IDLE;
	endsequence
	a_word_two_writes: assert property (@(posedge clock_i) disable iff (rst_i) // RQ4
		s_word_req |=> s_q.wb.we ##1 s_q.wb.we && s_q.st == slalu_pkg::SLALU_IDLE)
		else $error("word subtract did not write two bytes");
	a_short_one_cycle: assert property (@(posedge clock_i) disable iff (rst_i) // RQ1
		req_i.valid && req_i.op == `SLALU_OP_SUB_REG && s_q.st == slalu_pkg::SLALU_IDLE
		|=> s_q.wb.we && s_q.st == slalu_pkg::SLALU_IDLE)
		else $error("subtract not done in one cycle");
	a_logic_keeps_c: assert property (@(posedge clock_i) disable iff (rst_i) // RQ9
		s_q.fupd == 8'h0E |=> $stable(flags[`SLALU_FLAG_C]) && $stable(flags[`SLALU_FLAG_H]))
		else $error("logic op altered carry or half carry");
	a_logic_v_clear: assert property (@(posedge clock_i) disable iff (rst_i) // RQ5
		s_q.fupd == 8'h0E |=> !flags[`SLALU_FLAG_V])
		else $error("logic op left overflow set");
	a_idle_no_flags: assert property (@(posedge clock_i) disable iff (rst_i) // RQ9
		!s_q.wb.we |-> s_q.fupd == 8'h00)
		else $error("flags updated without an operation");

	sequence s_sub_req;
		req_i.valid && s_q.st == slalu_pkg::SLALU_IDLE
			&& (req_i.op == `SLALU_OP_SUB_REG || req_i.op == `SLALU_OP_SUB_IMM);
	endsequence
	sequence s_subb_reg_req;
		req_i.valid && s_q.st == slalu_pkg::SLALU_IDLE && req_i.op == `SLALU_OP_SUBB_REG;
	endsequence
	sequence s_subb_imm_req;
		req_i.valid && s_q.st == slalu_pkg::SLALU_IDLE && req_i.op == `SLALU_OP_SUBB_IMM;
	endsequence
	sequence s_logic_req;
		req_i.valid && s_q.st == slalu_pkg::SLALU_IDLE
			&& (req_i.op == `SLALU_OP_AND || req_i.op == `SLALU_OP_OR);
	endsequence
	sequence s_cmpl_req;
		req_i.valid && s_q.st == slalu_pkg::SLALU_IDLE
			&& (req_i.op == `SLALU_OP_INV || req_i.op == `SLALU_OP_TWOS);
	endsequence
	a_sub_flag_set: assert property (@(posedge clock_i) disable iff (rst_i) // RQ1
		s_sub_req |=> s_q.fupd == 8'h2F)
		else $error("subtract updated the wrong flags");
	a_subb_reg_flags: assert property (@(posedge clock_i) disable iff (rst_i) // RQ2
		s_subb_reg_req |=> s_q.fupd == 8'h2F && s_q.wb.we)
		else $error("register borrow subtract updated the wrong flags");
	a_subb_imm_flags: assert property (@(posedge clock_i) disable iff (rst_i) // RQ3
		s_subb_imm_req |=> s_q.fupd == 8'h2F && s_q.wb.we)
		else $error("immediate borrow subtract updated the wrong flags");
	a_word_flag_set: assert property (@(posedge clock_i) disable iff (rst_i) // RQ4
		s_word_req |=> s_q.fupd == 8'h1F)
		else $error("word subtract updated the wrong flags");
	a_word_busy_pulse: assert property (@(posedge clock_i) disable iff (rst_i) // RQ4
		s_word_req |=> busy_o ##1 !busy_o)
		else $error("busy not shown for exactly one cycle");
	a_logic_flag_set: assert property (@(posedge clock_i) disable iff (rst_i) // RQ6
		s_logic_req |=> s_q.fupd == 8'h0E && s_q.wb.we)
		else $error("and or or updated the wrong flags");
	a_xor_result: assert property (@(posedge clock_i) disable iff (rst_i) // RQ7
		req_i.valid && s_q.st == slalu_pkg::SLALU_IDLE && req_i.op == `SLALU_OP_XOR
		|=> s_q.wb.we && s_q.fupd == 8'h0E && s_q.wb.data == $past(req_i.rd ^ req_i.src_reg))
		else $error("exclusive or result or flags wrong");
	a_cmpl_no_flags: assert property (@(posedge clock_i) disable iff (rst_i) // RQ8
		s_cmpl_req |=> s_q.wb.we && s_q.fupd == 8'h00)
		else $error("complement did not write or touched flags");
endmodule

// ==== logic/slalu_map.svh ====
// Opcode codes, flag bit positions, reset values and cycle counts for the ALU slice
`ifndef SLALU_MAP_SVH
`define SLALU_MAP_SVH
`define SLALU_OP_SUB_REG 4'h0
`define SLALU_OP_SUB_IMM 4'h1
`define SLALU_OP_SUBB_REG 4'h2
`define SLALU_OP_SUBB_IMM 4'h3
`define SLALU_OP_WSUB_IMM 4'h4
`define SLALU_OP_AND 4'h5
`define SLALU_OP_OR 4'h6
`define SLALU_OP_XOR 4'h7
`define SLALU_OP_INV 4'h8
`define SLALU_OP_TWOS 4'h9
`define SLALU_FLAG_C 0
`define SLALU_FLAG_Z 1
`define SLALU_FLAG_N 2
`define SLALU_FLAG_V 3
`define SLALU_FLAG_S 4
`define SLALU_FLAG_H 5
`define SLALU_FLAGS_RST 8'h00
`define SLALU_CYC_SHORT 1
`define SLALU_CYC_WORD 2
`endif

// ==== logic/slalu_pkg.sv ====
// Types shared by the ALU slice
package slalu_pkg;
	typedef struct packed {
		logic valid;
		logic [3:0] op;
		logic [4:0] dst;
		logic [7:0] rd;
		logic [7:0] rdh;
		logic [7:0] src_reg;
		logic [7:0] imm;
	} slalu_req_t;
	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic [7:0] data;
	} slalu_wb_t;
	typedef enum logic [0:0] {
		SLALU_IDLE,
		SLALU_WORD_HI
	} slalu_state_t;
endpackage

// ==== logic/slalu_flag_reg.sv ====
// Status flag register with per-bit update mask
module slalu_flag_reg #(
	parameter int WIDTH = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] upd_i,
	input wire logic [WIDTH-1:0] val_i,
	output logic [WIDTH-1:0] flags_o
);
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					flags_o[i] <= 1'b0;
				end else if (upd_i[i]) begin
					flags_o[i] <= val_i[i];
				end
			end
		end
	endgenerate
endmodule

// ==== tb/slalu_rf_model.sv ====
// Register file model that absorbs write-back traffic
module slalu_rf_model (
	// Clock
	input wire logic clock_i,
	// Write-back from the slice
	input wire slalu_pkg::slalu_wb_t wb_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rf [32];
	int n_wr = 0;
	always @(posedge clock_i) begin
		if (wb_i.we === 1'b1) begin
			rf[wb_i.addr] <= wb_i.data;
			n_wr <= n_wr + 1;
		end
	end
endmodule

// ==== tb/slalu_top_tb.sv ====
// Self-checking bench for the ALU slice
module slalu_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ui = 1'b0;
	slalu_pkg::slalu_req_t req = '0;
	slalu_pkg::slalu_wb_t wb;
	logic busy;
	logic [7:0] flg;
	int num_errors = 0;
	int cmp_count = 0;
	always #2 clk = ~clk;
	slalu_top dut (.clock_i(clk), .rst_i(rst), .req_i(req), .use_imm_i(ui),
		.wb_o(wb), .busy_o(busy), .flags_o(flg));
	slalu_rf_model rfm (.clock_i(clk), .wb_i(wb));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Issue one op, check write-back two edges on and flags one edge later
	task automatic op(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
		input logic u, input logic [7:0] ed, input logic [7:0] ef, input logic [7:0] fm);
		@(negedge clk);
		req = '{1'b1, o, 5'h04, a, 8'h01, b, b};
		ui = u;
		@(negedge clk);
		req.valid = 1'b0;
		@(negedge clk);
		chk({7'h00, wb.we}, 8'h01);
		chk({3'h0, wb.addr}, 8'h04);
		chk(wb.data, ed);
		@(negedge clk);
		chk({7'h00, wb.we}, 8'h00);
		chk(flg & fm, ef & fm);
	endtask
	// Borrow op right after a subtract must see the fresh carry
	task automatic sub_then_subb();
		@(negedge clk);
		req = '{1'b1, 4'h0, 5'h04, 8'h00, 8'h01, 8'h01, 8'h01};
		ui = 1'b0;
		@(negedge clk);
		req = '{1'b1, 4'h2, 5'h05, 8'h05, 8'h01, 8'h02, 8'h02};
		@(negedge clk);
		req.valid = 1'b0;
		chk(wb.data, 8'hFF);
		@(negedge clk);
		chk({wb.we, 2'h0, wb.addr}, 8'h85);
		chk(wb.data, 8'h02);
		@(negedge clk);
		chk(flg & 8'h3F, 8'h00);
	endtask
	task automatic word_sub();
		@(negedge clk);
		req = '{1'b1, 4'h4, 5'h06, 8'h00, 8'h01, 8'h00, 8'h01};
		@(negedge clk);
		req.valid = 1'b0;
		chk({7'h00, busy}, 8'h01);
		@(negedge clk);
		chk({wb.we, 2'h0, wb.addr}, 8'h86);
		chk(wb.data, 8'hFF);
		@(negedge clk);
		chk({wb.we, 2'h0, wb.addr}, 8'h87);
		chk(wb.data, 8'h00);
		chk(flg & 8'h3F, 8'h20);
		@(negedge clk);
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk(flg, 8'h00);
		chk({7'h00, wb.we}, 8'h00);
		op(4'h0, 8'h00, 8'h01, 1'b0, 8'hFF, 8'h25, 8'h2F);
		op(4'h2, 8'h05, 8'h02, 1'b0, 8'h02, 8'h00, 8'h2F);
		op(4'h1, 8'h10, 8'h20, 1'b1, 8'hF0, 8'h05, 8'h2F);
		op(4'h3, 8'h10, 8'h0F, 1'b1, 8'h00, 8'h20, 8'h2F);
		op(4'h5, 8'hF0, 8'h0F, 1'b0, 8'h00, 8'h22, 8'h2F);
		op(4'h6, 8'h80, 8'h01, 1'b1, 8'h81, 8'h24, 8'h2F);
		op(4'h7, 8'hAA, 8'hAA, 1'b0, 8'h00, 8'h22, 8'h2F);
		op(4'h8, 8'h0F, 8'h00, 1'b0, 8'hF0, 8'h22, 8'h3F);
		op(4'h9, 8'h01, 8'h00, 1'b0, 8'hFF, 8'h22, 8'h3F);
		word_sub();
		chk(8'(rfm.n_wr), 8'h0B);
		sub_then_subb();
		finish_test();
	end
endmodule
